// [rtl/soc_pkg.sv]
// Constants, register map and carrier types for the oscillator calibration register bank.
// Assumes a 20 MHz device clock and an 8-bit register port with byte offsets.
package soc_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned SETTLE_UNIT_NS = 1000;
  localparam int unsigned SETTLE_UNIT_CYC_I = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SETTLE_UNIT_CYC = 8'(SETTLE_UNIT_CYC_I);

  localparam logic [7:0] ADDR_SYNTH_HOLD = 8'h5c;
  localparam logic [7:0] ADDR_OSC_CTRL   = 8'h5d;
  localparam logic [7:0] ADDR_OSC_STATE  = 8'h5e;
  localparam logic [7:0] ADDR_RUN_EN     = 8'h61;
  localparam logic [7:0] ADDR_CFG0       = 8'h62;

  localparam int unsigned HOLD_BIT     = 0;
  localparam int unsigned CAL_EN_BIT   = 0;
  localparam int unsigned CMPL_BIT     = 0;
  localparam int unsigned RUN_EN_BIT   = 0;
  localparam int unsigned SETTLE_LSB   = 4;
  localparam int unsigned SETTLE_MSB   = 6;
  localparam int unsigned FG_BIT       = 0;
  localparam int unsigned BG_BIT       = 1;
  localparam int unsigned FG_OS_BIT    = 2;
  localparam int unsigned BG_OS_BIT    = 3;

  localparam logic       HOLD_RST      = 1'h0;
  localparam logic [2:0] SETTLE_RST    = 3'h4;
  localparam logic       CAL_EN_RST    = 1'h0;
  localparam logic       RUN_EN_RST    = 1'h1;
  localparam logic [3:0] CFG0_RST      = 4'h1;

  localparam int unsigned TRIM_W       = 7;
  localparam logic [6:0]  TRIM_MID     = 7'h40;
  localparam logic [2:0]  TRIM_TOP_BIT = 3'h6;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } soc_reg_req_t;

  typedef struct packed {
    logic bg_offset;
    logic fg_offset;
    logic bg_cal;
    logic fg_cal;
  } soc_cal_cfg_t;

  typedef enum logic [1:0] {
    ENG_IDLE   = 2'b00,
    ENG_SETTLE = 2'b01,
    ENG_DECIDE = 2'b11,
    ENG_FINISH = 2'b10
  } soc_eng_state_t;

endpackage : soc_pkg

// [rtl/soc_osc_cal_engine.sv]
// Successive-approximation search of the oscillator frequency trim.
// Assumes osc_fast is already synchronised to ref_clk; a higher trim gives a faster oscillator.
module soc_osc_cal_engine (
  input  wire logic                 ref_clk,   // device clock
  input  wire logic                 reset_n,   // async reset, active low
  input  wire logic                 start,     // one-cycle start pulse
  input  wire logic                 abort,     // synthesizer held in reset
  input  wire logic [2:0]           settle,    // settle code
  input  wire logic                 osc_fast,  // comparator: oscillator above target
  output logic [soc_pkg::TRIM_W-1:0] trim,     // current trim
  output logic                      busy,      // search running
  output logic                      done       // one-cycle completion pulse
);
  import soc_pkg::*;

  soc_eng_state_t      st_r, st_nxt;
  logic [TRIM_W-1:0]   trim_r, trim_nxt;
  logic [2:0]          bit_r, bit_nxt;
  logic [7:0]          cnt_r, cnt_nxt;
  logic                done_r, done_nxt;

  always_comb
  begin
    st_nxt   = st_r;
    trim_nxt = trim_r;
    bit_nxt  = bit_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    case (st_r)
      ENG_IDLE:
        if (start && !abort)
        begin
          trim_nxt = TRIM_MID;
          bit_nxt  = TRIM_TOP_BIT;
          cnt_nxt  = 8'(({5'h0, settle} + 8'h1) * SETTLE_UNIT_CYC);
          st_nxt   = ENG_SETTLE;
        end
      ENG_SETTLE:
        if (cnt_r <= 8'h1)
          st_nxt = ENG_DECIDE;
        else
          cnt_nxt = cnt_r - 8'h1;
      ENG_DECIDE:
      begin
        if (osc_fast)
          trim_nxt[bit_r] = 1'b0;
        if (bit_r == 3'h0)
          st_nxt = ENG_FINISH;
        else
        begin
          trim_nxt[bit_r - 3'h1] = 1'b1;
          bit_nxt = bit_r - 3'h1;
          cnt_nxt = 8'(({5'h0, settle} + 8'h1) * SETTLE_UNIT_CYC);
          st_nxt  = ENG_SETTLE;
        end
      end
      ENG_FINISH:
      begin
        done_nxt = 1'b1;
        st_nxt   = ENG_IDLE;
      end
      default:
        st_nxt = ENG_IDLE;
    endcase
    if (abort && st_r != ENG_IDLE)
    begin
      st_nxt   = ENG_IDLE;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r   <= ENG_IDLE;
      trim_r <= '0;
      bit_r  <= '0;
      cnt_r  <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      trim_r <= trim_nxt;
      bit_r  <= bit_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign trim = trim_r;
  assign busy = (st_r != ENG_IDLE);
  assign done = done_r;

  settle_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_r == ENG_IDLE && start && !abort) |=> cnt_r == 8'(({5'h0, settle} + 8'h1) * SETTLE_UNIT_CYC))
    else $error("settle count not loaded from settle code");

  trim_moves_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $changed(trim_r) |-> $past(busy) || $past(start))
    else $error("trim changed outside a calibration");

endmodule // soc_osc_cal_engine

// [rtl/soc_cal_regs.sv]
// Synthesizer oscillator calibration and global calibration enable registers.
// Assumes a same-clock register port (one-cycle strobes) and an async comparator pin.
module soc_cal_regs (
  input  wire logic                 ref_clk,         // 20 MHz device clock
  input  wire logic                 reset_n,         // async reset, active low
  input  wire soc_pkg::soc_reg_req_t reg_req,        // register port request
  input  wire logic                 osc_fast_pin,    // async comparator, oscillator above target
  output logic [7:0]                reg_rdata,       // read data, valid cycle after rd
  output logic                      synth_hold,      // synthesizer held in reset
  output logic [soc_pkg::TRIM_W-1:0] osc_trim,       // oscillator frequency trim
  output logic                      cal_hold,        // calibration held in reset
  output logic                      div_reset,       // digital and serial-link divider reset
  output soc_pkg::soc_cal_cfg_t     cal_cfg,         // effective calibration enables
  output logic                      cal_values_rst,  // pulse: reset calibration values
  output logic                      fg_cal_start     // pulse: run foreground calibration
);
  import soc_pkg::*;

  function automatic logic hit(input soc_reg_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction

  logic        fast_s1_r, fast_s2_r;
  logic        hold_r, hold_nxt;
  logic [2:0]  settle_r, settle_nxt;
  logic        cal_en_r, cal_en_nxt;
  logic        cmpl_r, cmpl_nxt;
  logic        run_r, run_nxt;
  logic [3:0]  cfg_r, cfg_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        start_r, start_nxt;
  logic        hold_o_r, cal_hold_r, div_rst_r, vrst_r, fgst_r;
  logic        vrst_nxt, fgst_nxt;
  soc_cal_cfg_t cfg_o_r, cfg_o_nxt;
  logic [TRIM_W-1:0] eng_trim;
  logic        eng_busy, eng_done;
  logic        release_wr;

  // Comparator crosses from the analog side; only the second stage is used
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fast_s1_r <= 1'b0;
      fast_s2_r <= 1'b0;
    end
    else
    begin
      fast_s1_r <= osc_fast_pin;
      fast_s2_r <= fast_s1_r;
    end
  end

  soc_osc_cal_engine u_engine (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .start    (start_r),
    .abort    (hold_r),
    .settle   (settle_r),
    .osc_fast (fast_s2_r),
    .trim     (eng_trim),
    .busy     (eng_busy),
    .done     (eng_done)
  );

  assign release_wr = reg_req.wr && hit(reg_req, ADDR_SYNTH_HOLD) && hold_r && !reg_req.wdata[HOLD_BIT];

  always_comb
  begin
    hold_nxt   = hold_r;
    settle_nxt = settle_r;
    cal_en_nxt = cal_en_r;
    run_nxt    = run_r;
    cfg_nxt    = cfg_r;
    rdata_nxt  = rdata_r;
    // Only defined fields are stored, so reserved bits keep reading as defaults
    if (reg_req.wr)
    begin
      if (hit(reg_req, ADDR_SYNTH_HOLD))
        hold_nxt = reg_req.wdata[HOLD_BIT];
      else if (hit(reg_req, ADDR_OSC_CTRL))
      begin
        settle_nxt = reg_req.wdata[SETTLE_MSB:SETTLE_LSB];
        cal_en_nxt = reg_req.wdata[CAL_EN_BIT];
      end
      else if (hit(reg_req, ADDR_RUN_EN))
        run_nxt = reg_req.wdata[RUN_EN_BIT];
      else if (hit(reg_req, ADDR_CFG0))
        cfg_nxt = reg_req.wdata[BG_OS_BIT:FG_BIT];
    end
    if (reg_req.rd)
    begin
      rdata_nxt = 8'h00;
      if (hit(reg_req, ADDR_SYNTH_HOLD))
        rdata_nxt[HOLD_BIT] = hold_r;
      else if (hit(reg_req, ADDR_OSC_CTRL))
      begin
        rdata_nxt[SETTLE_MSB:SETTLE_LSB] = settle_r;
        rdata_nxt[CAL_EN_BIT] = cal_en_r;
      end
      else if (hit(reg_req, ADDR_OSC_STATE))
        rdata_nxt[CMPL_BIT] = cmpl_r;
      else if (hit(reg_req, ADDR_RUN_EN))
        rdata_nxt[RUN_EN_BIT] = run_r;
      else if (hit(reg_req, ADDR_CFG0))
        rdata_nxt[BG_OS_BIT:FG_BIT] = cfg_r;
    end

    start_nxt = release_wr && cal_en_nxt;
    cmpl_nxt  = cmpl_r;
    if (hold_nxt)
      cmpl_nxt = 1'b0;
    else if ((release_wr && !cal_en_nxt) || eng_done)
      cmpl_nxt = 1'b1;

    cfg_o_nxt.fg_cal    = cfg_nxt[FG_BIT];
    cfg_o_nxt.bg_cal    = cfg_nxt[BG_BIT];
    cfg_o_nxt.fg_offset = cfg_nxt[FG_OS_BIT] && cfg_nxt[FG_BIT];
    cfg_o_nxt.bg_offset = cfg_nxt[BG_OS_BIT] && cfg_nxt[BG_BIT];
    // Values are cleared on every run release; the foreground pass only when asked
    vrst_nxt = run_nxt && !run_r;
    fgst_nxt = run_nxt && !run_r && cfg_nxt[FG_BIT];
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_r     <= HOLD_RST;
      settle_r   <= SETTLE_RST;
      cal_en_r   <= CAL_EN_RST;
      cmpl_r     <= 1'b0;
      run_r      <= RUN_EN_RST;
      cfg_r      <= CFG0_RST;
      rdata_r    <= 8'h00;
      start_r    <= 1'b0;
      hold_o_r   <= HOLD_RST;
      cal_hold_r <= !RUN_EN_RST;
      div_rst_r  <= !RUN_EN_RST;
      cfg_o_r    <= soc_cal_cfg_t'(CFG0_RST);
      vrst_r     <= 1'b0;
      fgst_r     <= 1'b0;
    end
    else
    begin
      hold_r     <= hold_nxt;
      settle_r   <= settle_nxt;
      cal_en_r   <= cal_en_nxt;
      cmpl_r     <= cmpl_nxt;
      run_r      <= run_nxt;
      cfg_r      <= cfg_nxt;
      rdata_r    <= rdata_nxt;
      start_r    <= start_nxt;
      hold_o_r   <= hold_nxt;
      cal_hold_r <= !run_nxt;
      div_rst_r  <= !run_nxt;
      cfg_o_r    <= cfg_o_nxt;
      vrst_r     <= vrst_nxt;
      fgst_r     <= fgst_nxt;
    end
  end

  assign reg_rdata        = rdata_r;
  assign synth_hold       = hold_o_r;
  assign osc_trim         = eng_trim;
  assign cal_hold         = cal_hold_r;
  assign div_reset        = div_rst_r;
  assign cal_cfg          = cfg_o_r;
  assign cal_values_rst   = vrst_r;
  assign fg_cal_start     = fgst_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // A release may follow the hold write at once, so the second cycle is checked only while still held
  hold_clears_cmpl_a: assert property (
    (reg_req.wr && hit(reg_req, ADDR_SYNTH_HOLD) && reg_req.wdata[HOLD_BIT])
      |=> (hold_r && !cmpl_r) ##1 (!hold_r || !cmpl_r))
    else $error("complete bit not cleared by synth hold");
  skip_sets_cmpl_a: assert property (
    (release_wr && !cal_en_r && !(reg_req.wr && hit(reg_req, ADDR_OSC_CTRL))) |=> cmpl_r)
    else $error("skipped calibration did not report complete");
  release_starts_a: assert property (
    (release_wr && cal_en_r) |=> ##1 (eng_busy && !cmpl_r))
    else $error("calibration did not start on hold release");
  done_sets_cmpl_a: assert property (
    (eng_done && !hold_nxt) |=> cmpl_r)
    else $error("engine finish not reported");
  run_low_holds_a: assert property (
    (reg_req.wr && hit(reg_req, ADDR_RUN_EN) && !reg_req.wdata[RUN_EN_BIT]) |=> (cal_hold && !run_r))
    else $error("calibration not held while run enable low");
  div_follows_run_a: assert property (
    div_reset == !run_r)
    else $error("divider reset disagrees with run enable");
  cfg_read_a: assert property (
    (reg_req.rd && hit(reg_req, ADDR_CFG0) && !reg_req.wr) |=> reg_rdata == {4'h0, $past(cfg_r)})
    else $error("config readback wrong");
  fg_start_a: assert property (
    cal_values_rst |-> (fg_cal_start == cal_cfg.fg_cal))
    else $error("foreground start does not follow foreground bit");
  bg_write_a: assert property (
    (reg_req.wr && hit(reg_req, ADDR_CFG0)) |=> cal_cfg.bg_cal == $past(reg_req.wdata[BG_BIT]))
    else $error("background enable not taken");
  fg_os_gate_a: assert property (
    cal_cfg.fg_offset |-> (cal_cfg.fg_cal && cfg_r[FG_OS_BIT]))
    else $error("foreground offset without foreground");
  bg_os_gate_a: assert property (
    cal_cfg.bg_offset |-> (cal_cfg.bg_cal && cfg_r[BG_OS_BIT]))
    else $error("background offset without background");
  rsv_read_a: assert property (
    (reg_req.rd && hit(reg_req, ADDR_OSC_STATE)) |=> reg_rdata[7:1] == 7'h00)
    else $error("reserved status bits not zero");

  cal_run_c: cover property (release_wr && cal_en_r ##[1:1000] eng_done);
  cal_skip_c: cover property (release_wr && !cal_en_r);
  run_cycle_c: cover property (!run_r ##1 run_r ##1 fg_cal_start);
  offset_c: cover property (cal_cfg.bg_offset);

endmodule // soc_cal_regs

// [verif/soc_cal_regs_tb_top.sv]
// Self-checking bench for the oscillator calibration register bank.
// Assumes soc_pkg and soc_cal_regs are compiled first; inputs change on the falling edge.
module soc_cal_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import soc_pkg::*;

  logic                ref_clk;
  logic                reset_n;
  soc_reg_req_t        reg_req;
  logic                osc_fast_pin;
  logic [7:0]          reg_rdata;
  logic                synth_hold;
  logic [TRIM_W-1:0]   osc_trim;
  logic                cal_hold;
  logic                div_reset;
  soc_cal_cfg_t        cal_cfg;
  logic                cal_values_rst;
  logic                fg_cal_start;
  logic [TRIM_W-1:0]   target;
  int                  fails;
  int                  cmp_count;
  int                  cycles;

  // Comparator model: oscillator reads fast whenever the trim is above the target code
  // Updated on the falling edge like every other input; the settle wait hides the half cycle
  always @(negedge ref_clk)
    osc_fast_pin <= ((osc_trim > target) === 1'b1);

  soc_cal_regs u_soc_cal_regs (
    .ref_clk          (ref_clk),
    .reset_n          (reset_n),
    .reg_req          (reg_req),
    .osc_fast_pin     (osc_fast_pin),
    .reg_rdata        (reg_rdata),
    .synth_hold       (synth_hold),
    .osc_trim         (osc_trim),
    .cal_hold         (cal_hold),
    .div_reset        (div_reset),
    .cal_cfg          (cal_cfg),
    .cal_values_rst   (cal_values_rst),
    .fg_cal_start     (fg_cal_start)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard: the whole sequence needs under two thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_req.wr    = 1'b1;
    reg_req.addr  = a;
    reg_req.wdata = d;
    @(negedge ref_clk);
    reg_req.wr    = 1'b0;
  endtask

  // Extra cycle before sampling covers either reading of the one-cycle read latency
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_req.rd   = 1'b1;
    reg_req.addr = a;
    @(negedge ref_clk);
    reg_req.rd   = 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  task automatic wait_cmpl(input int max_reads);
    logic [7:0] d;
    int         i;
    d = 8'h00;
    for (i = 0; i < max_reads && d !== 8'h01; i++)
      rd(ADDR_OSC_STATE, d);
    check(d, 8'h01);
  endtask

  task automatic cal_run(input logic [7:0] ctrl);
    wr(ADDR_SYNTH_HOLD, 8'h01);
    rchk(ADDR_OSC_STATE, 8'h00);
    wr(ADDR_OSC_CTRL, ctrl);
    wr(ADDR_SYNTH_HOLD, 8'h00);
  endtask

  // Counts pulse cycles over a short window so a stuck or doubled pulse shows
  task automatic pulses(output int nv, output int nf);
    nv = 0;
    nf = 0;
    repeat (3)
    begin
      if (cal_values_rst === 1'b1)
        nv++;
      if (fg_cal_start === 1'b1)
        nf++;
      @(negedge ref_clk);
    end
  endtask

  logic [7:0] addrs  [6] = '{ADDR_SYNTH_HOLD, ADDR_OSC_CTRL, ADDR_OSC_STATE, ADDR_RUN_EN, ADDR_CFG0, 8'h60};
  logic [7:0] rst_v  [6] = '{8'h00, 8'h40, 8'h00, 8'h01, 8'h01, 8'h00};
  logic [7:0] ff_v   [6] = '{8'h01, 8'h71, 8'h00, 8'h01, 8'h0f, 8'h00};
  logic [7:0] tgts   [2] = '{8'h2b, 8'h00};
  logic [7:0] cfg_w  [6] = '{8'h01, 8'h00, 8'h0c, 8'h0f, 8'h06, 8'h09};
  logic [7:0] cfg_e  [6] = '{8'h01, 8'h00, 8'h00, 8'h0f, 8'h02, 8'h01};
  logic [7:0] fg_e   [6] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01};

  initial
  begin
    int nv;
    int nf;
    reset_n = 1'b0;
    reg_req = '0;
    target  = 7'h2b;
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    check({4'h0, cal_cfg}, 8'h01);
    check({6'h0, cal_hold, div_reset}, 8'h00);
    for (int i = 0; i < 6; i++)
      rchk(addrs[i], rst_v[i]);
    for (int i = 0; i < 6; i++)
      wr(addrs[i], 8'hff);
    for (int i = 0; i < 6; i++)
      rchk(addrs[i], ff_v[i]);
    check({7'h0, synth_hold}, 8'h01);
    wr(ADDR_CFG0, 8'h01);
    wr(ADDR_OSC_CTRL, 8'h40);
    wr(ADDR_SYNTH_HOLD, 8'h00);
    rchk(ADDR_OSC_STATE, 8'h01);
    check({7'h0, synth_hold}, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      target = tgts[i][6:0];
      cal_run(8'h01);
      wait_cmpl(100);
      check({1'b0, osc_trim}, tgts[i]);
    end
    target = 7'h2b;
    cal_run(8'h11);
    repeat (200) @(negedge ref_clk);
    rchk(ADDR_OSC_STATE, 8'h00);
    wait_cmpl(150);
    check({1'b0, osc_trim}, 8'h2b);
    cal_run(8'h41);
    repeat (50) @(negedge ref_clk);
    wr(ADDR_SYNTH_HOLD, 8'h01);
    repeat (900) @(negedge ref_clk);
    rchk(ADDR_OSC_STATE, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_RUN_EN, 8'h00);
      wr(ADDR_CFG0, cfg_w[i]);
      rchk(ADDR_CFG0, cfg_w[i]);
      check({4'h0, cal_cfg}, cfg_e[i]);
      check({6'h0, cal_hold, div_reset}, 8'h03);
      rchk(ADDR_RUN_EN, 8'h00);
      wr(ADDR_RUN_EN, 8'h01);
      pulses(nv, nf);
      check(8'(nv), 8'h01);
      check(8'(nf), fg_e[i]);
      check({6'h0, cal_hold, div_reset}, 8'h00);
    end
    final_report();
  end

endmodule // soc_cal_regs_tb_top
